//--- verilog/tcp_timer.sv
// Four-channel 16-bit compare/capture/PWM timer with an APB register slave.
// Pin inputs are taken as synchronous to clk; a capture edge is seen in the
// cycle in which it occurs on the input.
//
// The implementer's own choices: the address map and the APB register port.

module tcp_timer
   import tcp_pkg::*;
#(
   parameter int CW = 16 // Counter width
) (
   input wire logic clk, // 40 MHz clock
   input wire logic rst, // Async reset, active high
   input wire logic psel, // APB select
   input wire logic penable, // APB enable
   input wire logic pwrite, // APB direction
   input wire logic [7:0] paddr, // APB byte address
   input wire logic [31:0] pwdata, // APB write data
   output logic [31:0] prdata, // APB read data
   output logic pready, // APB ready
   output logic pslverr, // APB error for unmapped address
   input wire logic [3:0] pinIn, // Timer pin levels A..D
   output tcp_pins_t pinOut, // Timer pin drive and enables
   output logic irq // Combined interrupt request
);
   logic [7:0] mode, ctrl1, ctrl2, irqEn, status;
   logic [15:0] ioSel;
   logic [CW-1:0] count;
   logic [CW-1:0] gr [4];
   logic [3:0] pinPrev;
   logic [3:0] level;

   // Bus decode; one wait-free access phase
   wire access = psel && penable;
   wire wr = access && pwrite;
   wire hitMode = paddr == OFS_MODE;
   wire hitCtrl1 = paddr == OFS_CTRL1;
   wire hitCtrl2 = paddr == OFS_CTRL2;
   wire hitIrqEn = paddr == OFS_IRQEN;
   wire hitStatus = paddr == OFS_STATUS;
   wire hitIoSel = paddr == OFS_IOSEL;
   wire hitCount = paddr == OFS_COUNT;
   wire [3:0] hitGr = {paddr == OFS_GRD, paddr == OFS_GRC, paddr == OFS_GRB,
      paddr == OFS_GRA};
   wire mapped = hitMode | hitCtrl1 | hitCtrl2 | hitIrqEn | hitStatus | hitIoSel
      | hitCount | (|hitGr);

   // Counter control
   wire running = mode[MODE_CTS];
   wire clrOnA = ctrl1[CTRL1_CLEAR_ON_MATCH_A];
   wire [3:0] pwmSel = {mode[MODE_PWM_SELECT_B+2:MODE_PWM_SELECT_B], 1'b0};
   wire anyPwm = |pwmSel;
   wire [3:0] match;
   wire [3:0] capEvt;
   wire periodClr = running && match[0] && (clrOnA || anyPwm);
   wire wrap = running && !periodClr && count == COUNT_MAX;
   wire [CW-1:0] next_count = periodClr ? COUNT_ZERO : count + 1'b1;

   // Per-pin compare, capture and output action
   logic [3:0] next_level;
   logic [3:0] capMode;
   logic [3:0] pinOe;
   genvar i;
   for (i = 0; i < 4; i++) begin : gPin
      wire [3:0] sel = ioSel[i*IOSEL_W +: IOSEL_W];
      assign capMode[i] = sel[IOSEL_CAP] && !pwmSel[i];
      assign match[i] = running && count == gr[i] && !capMode[i];
      wire rise = pinIn[i] && !pinPrev[i];
      wire fall = !pinIn[i] && pinPrev[i];
      // Edge select: 00 rising, 01 falling, 1x both
      assign capEvt[i] = running && capMode[i] && (sel[1] ? (rise || fall) :
         (sel[0] ? fall : rise));
      wire pol = ctrl2[(i == 0) ? 0 : i-1];
      // PWM: own match sets active level, match A sets inactive level
      wire pwmOwn = pol;
      logic nl;
      always_comb begin
         nl = level[i];
         if (pwmSel[i]) begin
            // Equal period and duty: both matches cancel, output holds
            if (match[i] && match[0]) begin
               nl = level[i];
            end else if (match[i]) begin
               nl = pwmOwn;
            end else if (match[0]) begin
               nl = !pwmOwn;
            end
         end else if (match[i] && !capMode[i]) begin
            unique case (sel[1:0])
               2'h1: nl = 1'b0;
               2'h2: nl = 1'b1;
               2'h3: nl = !level[i];
               default: nl = level[i];
            endcase
         end
      end
      assign next_level[i] = nl;
      assign pinOe[i] = pwmSel[i] || (!capMode[i] && sel[1:0] != 2'h0);
   end

   // Initial level: timer mode takes the bit; PWM uses level XNOR polarity
   function automatic logic [3:0] initLevel(input logic [7:0] c1, input logic [7:0] c2,
      input logic [3:0] pw);
      logic [3:0] r;
      r = c1[3:0];
      for (int k = 1; k < 4; k++) begin
         if (pw[k]) r[k] = !(c1[k] ^ c2[k-1]);
      end
      return r;
   endfunction : initLevel

   // Read mux
   logic [31:0] rdMux;
   always_comb begin
      rdMux = 32'h00000000;
      if (hitMode) rdMux[7:0] = mode;
      if (hitCtrl1) rdMux[7:0] = ctrl1;
      if (hitCtrl2) rdMux[7:0] = ctrl2;
      if (hitIrqEn) rdMux[7:0] = irqEn;
      if (hitStatus) rdMux[7:0] = status;
      if (hitIoSel) rdMux[15:0] = ioSel;
      if (hitCount) rdMux[CW-1:0] = count;
      for (int k = 0; k < 4; k++) begin
         if (hitGr[k]) rdMux[CW-1:0] = gr[k];
      end
   end

   // Control registers; initial pin levels load from them while the counter is stopped
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         mode <= 8'h00;
         ctrl1 <= 8'h00;
         ctrl2 <= 8'h00;
         irqEn <= 8'h00;
         ioSel <= 16'h0000;
      end else if (wr) begin
         if (hitMode) mode <= pwdata[7:0];
         if (hitCtrl1) ctrl1 <= pwdata[7:0];
         if (hitCtrl2) ctrl2 <= pwdata[7:0];
         if (hitIrqEn) irqEn <= pwdata[7:0];
         if (hitIoSel) ioSel <= pwdata[15:0];
      end
   end

   // Counter; a software write wins over counting
   always_ff @(posedge clk or posedge rst) begin
      if (rst) count <= COUNT_ZERO;
      else if (wr && hitCount) count <= pwdata[CW-1:0];
      else if (running) count <= next_count;
   end

   // General registers: capture, buffer transfers, software writes
   for (i = 0; i < 4; i++) begin : gGr
      logic [CW-1:0] nextGr;
      always_comb begin
         nextGr = gr[i];
         if (wr && hitGr[i]) nextGr = pwdata[CW-1:0];
         if (capEvt[i]) nextGr = count;
         if (i == 2 && mode[MODE_BUFA] && capEvt[0]) nextGr = gr[0];
         if (i == 1 && mode[MODE_BUFB] && match[1] && !capMode[1]) nextGr = gr[3];
      end
      always_ff @(posedge clk or posedge rst) begin
         if (rst) gr[i] <= GR_RESET;
         else gr[i] <= nextGr;
      end
   end

   // Status flags: hardware set wins over a write-0 clear
   wire [7:0] setEvt = {wrap, 3'b000, match | capEvt};
   always_ff @(posedge clk or posedge rst) begin
      if (rst) status <= 8'h00;
      else if (wr && hitStatus) status <= (status & pwdata[7:0]) | setEvt;
      else status <= status | setEvt;
   end

   // Pin levels; stopped counter holds initial levels
   always_ff @(posedge clk or posedge rst) begin
      if (rst) level <= 4'h0;
      else if (!running) level <= initLevel(ctrl1, ctrl2, pwmSel);
      else level <= next_level;
   end

   // Registered outputs
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         pinPrev <= 4'h0;
         pinOut <= '0;
         irq <= 1'b0;
         prdata <= 32'h00000000;
         pready <= 1'b0;
         pslverr <= 1'b0;
      end else begin
         pinPrev <= pinIn;
         pinOut.level <= level;
         pinOut.oe <= pinOe;
         irq <= |(status & irqEn);
         pready <= psel && !penable;
         pslverr <= psel && !penable && !mapped;
         prdata <= rdMux;
      end
   end
endmodule : tcp_timer

//--- common/tcp_pkg.sv
// Package for the compare/capture/PWM timer: register map, field layout,
// reset values and the carrier struct for the four timer pins.
// Assumes a 32-bit APB with one register per aligned word.
package tcp_pkg;
   localparam logic [7:0] OFS_MODE = 8'h00;
   localparam logic [7:0] OFS_CTRL1 = 8'h04;
   localparam logic [7:0] OFS_CTRL2 = 8'h08;
   localparam logic [7:0] OFS_IRQEN = 8'h0C;
   localparam logic [7:0] OFS_STATUS = 8'h10;
   localparam logic [7:0] OFS_IOSEL = 8'h14;
   localparam logic [7:0] OFS_COUNT = 8'h18;
   localparam logic [7:0] OFS_GRA = 8'h1C;
   localparam logic [7:0] OFS_GRB = 8'h20;
   localparam logic [7:0] OFS_GRC = 8'h24;
   localparam logic [7:0] OFS_GRD = 8'h28;
   // Mode register fields
   localparam int MODE_PWM_SELECT_B = 0;
   localparam int MODE_BUFA = 4;
   localparam int MODE_BUFB = 5;
   localparam int MODE_CTS = 7;
   // Control 1: initial levels in bits 3:0 (A..D), clear on match A in bit 7
   localparam int CTRL1_CLEAR_ON_MATCH_A = 7;
   // Control 2: polarity B..D in bits 2:0
   // IO select: 4 bits per pin, pin A in bits 3:0; bit2 = capture, bits1:0 = action/edge
   localparam int IOSEL_W = 4;
   localparam int IOSEL_CAP = 2;
   // Status/irq-enable: bits 3:0 match or capture A..D, bit 7 overflow
   localparam int STAT_OVF = 7;
   localparam logic [15:0] COUNT_MAX = 16'hFFFF;
   localparam logic [15:0] COUNT_ZERO = 16'h0000;
   localparam logic [15:0] GR_RESET = 16'hFFFF;

   typedef struct packed {
      logic [3:0] level; // Pin output levels A..D
      logic [3:0] oe;    // Pin output enables A..D
   } tcp_pins_t;
endpackage : tcp_pkg

//--- verification/tcp_timer_assertions.sv
// Checker for the timer's APB slave and pin enables.
// Bound to tcp_timer from the bench; sees its ports only.
module tcp_timer_assertions
   import tcp_pkg::*;
(
   input wire logic clk, // Clock
   input wire logic rst, // Async reset
   input wire logic psel, // APB select
   input wire logic penable, // APB enable
   input wire logic pwrite, // APB direction
   input wire logic [7:0] paddr, // APB address
   input wire logic [31:0] pwdata, // APB write data
   input wire logic [31:0] prdata, // APB read data
   input wire logic pready, // APB ready
   input wire logic pslverr, // APB error
   input wire logic [3:0] pinIn, // Pin levels
   input wire tcp_pins_t pinOut, // Pin drive
   input wire logic irq // Interrupt
);
   default clocking cb @(posedge clk); endclocking
   default disable iff (rst);
   // Word addresses that hold a register
   wire mapped = (paddr <= OFS_GRD) && (paddr[1:0] == 2'h0);
   wire wrAcc = psel && penable && pwrite;
   property p_ready; psel && !penable |=> pready; endproperty
   a_ready: assert property (p_ready) else $error("ready missing");
   property p_pulse; pready |=> !pready; endproperty
   a_pulse: assert property (p_pulse) else $error("ready too long");
   property p_inacc; pready |-> psel && penable; endproperty
   a_inacc: assert property (p_inacc) else $error("ready outside access");
   property p_errrdy; pslverr |-> pready && !mapped; endproperty
   a_errrdy: assert property (p_errrdy) else $error("bad error");
   property p_okmap; psel && !penable && mapped |=> !pslverr; endproperty
   a_okmap: assert property (p_okmap) else $error("error on mapped");
   property p_rdzero; pslverr && !pwrite |-> prdata == 32'h0; endproperty
   a_rdzero: assert property (p_rdzero) else $error("unmapped data");
   property p_stat; pready && !pwrite && paddr == OFS_STATUS |-> prdata[31:8] == 24'h0; endproperty
   a_stat: assert property (p_stat) else $error("status upper bits");
   // Enables follow configuration only, so they hold without writes
   property p_oe; !wrAcc [*2] |=> $stable(pinOut.oe); endproperty
   a_oe: assert property (p_oe) else $error("enable moved");
endmodule : tcp_timer_assertions

//--- verification/tcp_pin_model.sv
// Circuitry on the four timer pins.
// A pin the timer drives reads its own level; others take drv.
module tcp_pin_model
   import tcp_pkg::*;
(
   input wire tcp_pins_t pinOut, // Timer pin drive
   input wire logic [3:0] drv, // Outside level
   output logic [3:0] pinIn // Resolved levels
);
   // Wire level from the timer's enables; drv has none
   assign pinIn = (pinOut.oe & pinOut.level) | (~pinOut.oe & drv);
endmodule : tcp_pin_model

//--- verification/tb_tcp_timer.sv
// Self-checking bench for tcp_timer.
// Needs tcp_pkg, the pin model and the checker.
module tb_tcp_timer
   import tcp_pkg::*;
;
   timeunit 1ns;
   timeprecision 100ps;
   logic clk = 0, rst = 1, psel = 0, penable = 0, pwrite = 0, err;
   logic [7:0] paddr = 8'h00;
   logic [31:0] pwdata = 32'h0, prdata, r, v;
   logic pready, pslverr, irq;
   logic [3:0] pinIn, drv = 4'h0;
   tcp_pins_t pinOut;
   int err_count = 0, check_count = 0, cyc = 0, n;
   wire [4:0] obs = {irq, pinOut.level};
   tcp_timer dut_u (.clk, .rst, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata,
      .pready, .pslverr, .pinIn, .pinOut, .irq);
   tcp_pin_model pin_u (.pinOut, .drv, .pinIn);
   initial begin
      forever #12.5 clk = ~clk;
   end
   task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
      check_count++;
      if (seen !== exp) begin
         err_count++;
         $display("CHECK FAILED %s expected %h seen %h", nm, exp, seen);
      end
   endtask : chk
   // One APB transfer; idle edge first so requests never collide
   task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
      @(posedge clk);
      psel <= 1'b1;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge clk);
      penable <= 1'b1;
      @(posedge clk);
      while (pready !== 1'b1) @(posedge clk);
      r = prdata;
      err = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask : apb
   task automatic rd(input string nm, input logic [7:0] a, input logic [31:0] e);
      apb(1'b0, a, 32'h0);
      chk(nm, r, e);
   endtask : rd
   task automatic rst10();
      rst <= 1'b1;
      drv <= 4'h0;
      repeat (10) @(posedge clk);
      rst <= 1'b0;
   endtask : rst10
   // Bounded wait for one observed bit, then judge it
   task automatic waitBit(input int k, input logic val);
      n = 0;
      while (obs[k] !== val && n < 300) begin
         @(posedge clk);
         n++;
      end
      chk("wait", 32'(obs[k]), 32'(val));
   endtask : waitBit
   task automatic t_idle();
      rst10();
      rd("gra", OFS_GRA, 32'h0000FFFF);
      repeat (5) @(posedge clk);
      rd("count idle", OFS_COUNT, 32'h0);
      apb(1'b0, 8'h40, 32'h0);
      chk("unmapped", {err, r[30:0]}, 32'h80000000);
   endtask : t_idle
   task automatic t_period();
      rst10();
      apb(1'b1, OFS_GRA, 32'h10);
      apb(1'b1, OFS_CTRL1, 32'h80);
      apb(1'b1, OFS_IRQEN, 32'h01);
      apb(1'b1, OFS_MODE, 32'h80);
      waitBit(4, 1'b1);
      rd("status", OFS_STATUS, 32'h01);
      apb(1'b0, OFS_COUNT, 32'h0);
      chk("cleared", 32'(r <= 32'h10), 32'h1);
   endtask : t_period
   task automatic t_wrap();
      rst10();
      apb(1'b1, OFS_COUNT, 32'hFFF0);
      apb(1'b1, OFS_IRQEN, 32'h80);
      apb(1'b1, OFS_MODE, 32'h80);
      waitBit(4, 1'b1);
      rd("flags", OFS_STATUS, 32'h8F);
      apb(1'b0, OFS_COUNT, 32'h0);
      chk("wrapped", 32'(r < 32'h40), 32'h1);
   endtask : t_wrap
   task automatic t_compare();
      rst10();
      for (int i = 0; i < 3; i++) apb(1'b1, OFS_GRA + 8'(4 * i), 32'h20);
      apb(1'b1, OFS_IOSEL, 32'h0312);
      apb(1'b1, OFS_CTRL1, 32'h04);
      repeat (4) @(posedge clk);
      chk("init", 32'({pinOut.oe[2:0], pinOut.level[2:0]}), 32'h3C);
      apb(1'b1, OFS_MODE, 32'h80);
      waitBit(0, 1'b1);
      chk("compare", 32'(pinOut.level[2:0]), 32'h1);
   endtask : t_compare
   task automatic t_capture();
      rst10();
      apb(1'b1, OFS_IOSEL, 32'h0056);
      apb(1'b1, OFS_MODE, 32'h90);
      drv <= 4'h3;
      repeat (6) @(posedge clk);
      rd("fall only", OFS_GRB, 32'hFFFF);
      rd("buf first", OFS_GRC, 32'hFFFF);
      apb(1'b0, OFS_GRA, 32'h0);
      v = r;
      drv <= 4'h0;
      repeat (6) @(posedge clk);
      rd("buf move", OFS_GRC, v);
      apb(1'b0, OFS_GRA, 32'h0);
      rd("same edge", OFS_GRB, r);
      chk("later", 32'(r > v), 32'h1);
   endtask : t_capture
   task automatic t_pwm();
      rst10();
      apb(1'b1, OFS_IOSEL, 32'h0020);
      apb(1'b1, OFS_GRA, 32'h40);
      apb(1'b1, OFS_GRB, 32'h10);
      apb(1'b1, OFS_MODE, 32'h01);
      // Level table walked down to 0,0 so the run starts high
      for (int i = 3; i >= 0; i--) begin
         apb(1'b1, OFS_CTRL1, 32'(i[1]) << 1);
         apb(1'b1, OFS_CTRL2, 32'(i[0]));
         repeat (4) @(posedge clk);
         chk("pwm init", 32'(pinOut.level[1]), 32'(i[1] == i[0]));
      end
      apb(1'b1, OFS_MODE, 32'h81);
      waitBit(1, 1'b0);
      @(posedge clk);
      waitBit(1, 1'b1);
      chk("low width", 32'(n + 1), 32'h30);
   endtask : t_pwm
   task automatic summarize();
      if (err_count == 0 && check_count > 0) $display("STATUS OK");
      else $display("STATUS NOT OK");
      $finish;
   endtask : summarize
   // Ceiling well above the sum of all scenarios
   always @(posedge clk) begin
      cyc++;
      if (cyc == 20000) begin
         err_count++;
         summarize();
      end
   end
   initial begin
      t_idle();
      t_period();
      t_wrap();
      t_compare();
      t_capture();
      t_pwm();
      summarize();
   end
endmodule : tb_tcp_timer
bind tcp_timer tcp_timer_assertions chk_u (.clk, .rst, .psel, .penable, .pwrite, .paddr,
   .pwdata, .prdata, .pready, .pslverr, .pinIn, .pinOut, .irq);
